/* logic/tcp_pkg.sv */
// Purpose: shared constants and types of the cascaded 16-bit timer
// Assumes: one system clock; prescaler taps arrive as one-cycle ticks
// Notes:   control byte holds only the run and flop preset bits
`default_nettype none
package tcp_pkg;

  localparam int          CNT_W      = 16;
  localparam int          BYTE_W     = 8;
  localparam int          RUN_BIT    = 3;
  localparam int          FFI_BIT    = 7;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CTRL_MASK  = 8'h88;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] CNT_TOP    = 16'hFFFF;
  localparam logic [7:0]  CMP_RST    = 8'h00;
  localparam logic        FLOP_RST   = 1'b0;

  typedef enum logic [2:0]
  {
    TCP_MODE_TIMER = 3'b001,
    TCP_MODE_EVENT = 3'b010,
    TCP_MODE_PWM   = 3'b100
  } tcp_mode_t;

  typedef enum logic [2:0]
  {
    TCP_SRC_TAP0 = 3'h0,
    TCP_SRC_TAP1 = 3'h1,
    TCP_SRC_TAP2 = 3'h2,
    TCP_SRC_TAP3 = 3'h3,
    TCP_SRC_LF   = 3'h4,
    TCP_SRC_HF2  = 3'h5,
    TCP_SRC_HF   = 3'h6,
    TCP_SRC_EXT  = 3'h7
  } tcp_src_t;

  typedef struct packed
  {
    logic hf_div2048;
    logic lf_div8;
    logic hf_div128;
    logic hf_div32;
    logic hf_div8;
    logic lf;
    logic hf_div2;
    logic hf;
  } tcp_ticks_t;

  typedef struct packed
  {
    logic low_speed;
    logic prescaler_tap_select;
  } tcp_clk_cfg_t;

  typedef struct packed
  {
    logic       wr;
    logic [7:0] data;
  } tcp_ctrl_wr_t;

  typedef struct packed
  {
    logic       wr_low;
    logic       wr_high;
    logic [7:0] data;
  } tcp_cmp_wr_t;

endpackage
`default_nettype wire

/* logic/tcp_edge_sync.sv */
// Purpose: synchronise the external count pin and flag falling edges
// Assumes: pin is asynchronous to clock
// Notes:   a level counts once the second and third stage agree
`default_nettype none
`timescale 1ns/1ns
module tcp_edge_sync
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic pin,
  output var  logic fall
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic fall_ff;
  wire  agree;
  wire  nxt_fall;

  assign agree    = (s2_ff == s3_ff);
  assign nxt_fall = agree & level_ff & ~s2_ff;
  assign fall     = fall_ff;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_ff    <= 1'b1;
      s2_ff    <= 1'b1;
      s3_ff    <= 1'b1;
      level_ff <= 1'b1;
      fall_ff  <= 1'b0;
    end
    else if (ce)
    begin
      s1_ff    <= pin;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= agree ? s2_ff : level_ff;
      fall_ff  <= nxt_fall;
    end
  end

endmodule
`default_nettype wire

/* logic/tcp_timer16.sv */
// Purpose: cascaded 16-bit timer, event counter and PWM generator
// Assumes: taps are same-clock one-cycle ticks from a shared prescaler
// Notes:   8-bit, PPG and warm-up modes are not covered here
`default_nettype none
`timescale 1ns/1ns
module tcp_timer16
  import tcp_pkg::*;
#(
  parameter int CNT_WIDTH = 16
)
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire tcp_pkg::tcp_mode_t    mode,
  input  wire tcp_pkg::tcp_src_t     src_sel,
  input  wire tcp_pkg::tcp_clk_cfg_t clk_cfg,
  input  wire tcp_pkg::tcp_ticks_t   ticks,
  input  wire tcp_pkg::tcp_ctrl_wr_t ctrl_wr,
  input  wire tcp_pkg::tcp_cmp_wr_t  period_wr,
  input  wire tcp_pkg::tcp_cmp_wr_t  duty_wr,
  input  wire logic              external_count_input,
  output var  logic [7:0]        upper_control_register,
  output var  logic [15:0]       period_compare,
  output var  logic [15:0]       duty_compare,
  output var  logic [15:0]       count_value,
  output var  logic              output_toggle_flop,
  output var  logic              modulated_output_pin,
  output var  logic              cascade_match_irq
);

  import tcp_pkg::*;

  if (CNT_WIDTH != CNT_W)
  begin : g_width_check
    $error("tcp_timer16: only a 16-bit cascade is supported");
  end

  logic [7:0]  ctrl_ff;
  logic [15:0] count_ff;
  logic [7:0]  period_compare_low_ff;
  logic [7:0]  period_compare_high_ff;
  logic [7:0]  duty_compare_low_ff;
  logic [7:0]  duty_compare_high_ff;
  logic [7:0]  dbuf_low_ff;
  logic [7:0]  dbuf_high_ff;
  logic        dpend_ff;
  logic        flop_ff;
  logic        pin_ff;
  logic        irq_ff;

  wire         ext_fall;
  wire         run;
  wire         is_pwm;
  wire         tap0;
  wire         step;
  wire [15:0]  period_val;
  wire [15:0]  duty_val;
  wire [15:0]  count_plus;
  wire         period_hit;
  wire         overflow;
  wire         duty_hit;
  wire         irq_evt;
  wire         toggle;
  wire         next_run;
  wire         preset;
  wire         buffered;
  wire         xfer;
  wire [7:0]   nxt_dbuf_low;
  wire [7:0]   nxt_dbuf_high;
  wire [15:0]  nxt_count;
  wire         nxt_flop;

  tcp_edge_sync u_sync
  (
    .clock (clock),
    .rst_b (rst_b),
    .ce    (ce),
    .pin   (external_count_input),
    .fall  (ext_fall)
  );

  // selects the counting tick for the current mode and power state
  function automatic logic pick_tick
  (
    input tcp_mode_t    m,
    input tcp_src_t     s,
    input tcp_clk_cfg_t c,
    input tcp_ticks_t   t,
    input logic         t0,
    input logic         ef
  );
    logic r;
    r = 1'b0;
    unique case (m)
      TCP_MODE_EVENT:
        r = ef;
      TCP_MODE_TIMER:
      begin
        unique case (s)
          TCP_SRC_TAP0: r = t0;
          TCP_SRC_TAP1: r = t.hf_div128 & ~c.low_speed;
          TCP_SRC_TAP2: r = t.hf_div32 & ~c.low_speed;
          TCP_SRC_TAP3: r = t.hf_div8 & ~c.low_speed;
          default:      r = 1'b0;
        endcase
      end
      TCP_MODE_PWM:
      begin
        unique case (s)
          TCP_SRC_TAP0: r = t0;
          TCP_SRC_TAP1: r = t.hf_div128 & ~c.low_speed;
          TCP_SRC_TAP2: r = t.hf_div32 & ~c.low_speed;
          TCP_SRC_TAP3: r = t.hf_div8 & ~c.low_speed;
          TCP_SRC_LF:   r = t.lf;
          TCP_SRC_HF2:  r = t.hf_div2 & ~c.low_speed;
          TCP_SRC_HF:   r = t.hf & ~c.low_speed;
          TCP_SRC_EXT:  r = ef;
        endcase
      end
      default:
        r = 1'b0;
    endcase
    return r;
  endfunction

  assign run        = ctrl_ff[RUN_BIT];
  assign is_pwm     = (mode == TCP_MODE_PWM);
  // first tap falls back to lf/8 when selected or in low speed
  assign tap0       = (clk_cfg.prescaler_tap_select | clk_cfg.low_speed)
                      ? ticks.lf_div8 : ticks.hf_div2048;
  // extra PWM taps; hf and hf/2 are gated in low speed, lf and ext are not
  assign step       = run & pick_tick(mode, src_sel, clk_cfg, ticks,
                                      tap0, ext_fall);

  assign period_val = {period_compare_high_ff, period_compare_low_ff};
  assign duty_val   = {duty_compare_high_ff, duty_compare_low_ff};
  assign count_plus = count_ff + CNT_ONE;
  assign period_hit = (count_plus == period_val);
  assign overflow   = (count_ff == CNT_TOP);
  assign duty_hit   = (count_plus == duty_val);

  // period match in timer and event modes
  assign irq_evt    = step & (is_pwm ? overflow : period_hit);

  // duty match and overflow both invert; zero duty cancels out
  assign toggle     = step & is_pwm & (overflow ^ duty_hit);

  // stopped counter is held at zero
  assign nxt_count  = !run ? CNT_RST
                      : (irq_evt ? CNT_RST
                      : (step ? count_plus : count_ff));

  assign next_run   = ctrl_wr.data[RUN_BIT];
  // preset only by a write made while already stopped
  assign preset     = ctrl_wr.wr & ~run & ~next_run;
  // preset from bit 7 else toggle
  assign nxt_flop   = preset ? ctrl_wr.data[FFI_BIT]
                      : (toggle ? ~flop_ff : flop_ff);

  // running PWM duty writes go to the buffer
  assign buffered      = is_pwm & run;
  assign nxt_dbuf_low  = (buffered & duty_wr.wr_low)
                         ? duty_wr.data : dbuf_low_ff;
  assign nxt_dbuf_high = (buffered & duty_wr.wr_high)
                         ? duty_wr.data : dbuf_high_ff;
  assign xfer          = irq_evt & is_pwm & dpend_ff;

  assign upper_control_register = ctrl_ff;
  assign period_compare         = period_val;
  // readback is the active duty value
  assign duty_compare           = duty_val;
  assign count_value            = count_ff;
  assign output_toggle_flop     = flop_ff;
  assign modulated_output_pin   = pin_ff;
  assign cascade_match_irq      = irq_ff;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_ff  <= CTRL_RST;
      count_ff <= CNT_RST;
      irq_ff   <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_ff  <= ctrl_wr.wr ? (ctrl_wr.data & CTRL_MASK) : ctrl_ff;
      count_ff <= nxt_count;
      irq_ff   <= irq_evt;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flop_ff <= FLOP_RST;
      pin_ff  <= ~FLOP_RST;
    end
    else if (ce)
    begin
      flop_ff <= nxt_flop;
      // pin is the inverse of the flop
      pin_ff  <= ~nxt_flop;
    end
  end

  // period bytes land directly, one strobe per byte
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      period_compare_low_ff  <= CMP_RST;
      period_compare_high_ff <= CMP_RST;
    end
    else if (ce)
    begin
      if (period_wr.wr_low)
        period_compare_low_ff <= period_wr.data;
      if (period_wr.wr_high)
        period_compare_high_ff <= period_wr.data;
    end
  end

  // duty buffer and transfer at the irq
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dbuf_low_ff          <= CMP_RST;
      dbuf_high_ff         <= CMP_RST;
      dpend_ff             <= 1'b0;
      duty_compare_low_ff  <= CMP_RST;
      duty_compare_high_ff <= CMP_RST;
    end
    else if (ce)
    begin
      dbuf_low_ff  <= nxt_dbuf_low;
      dbuf_high_ff <= nxt_dbuf_high;
      // a high-byte write in the transfer cycle keeps the flag set
      dpend_ff     <= (buffered & duty_wr.wr_high) | (dpend_ff & ~xfer);
      if (xfer)
      begin
        duty_compare_low_ff  <= nxt_dbuf_low;
        duty_compare_high_ff <= nxt_dbuf_high;
      end
      else if (!buffered)
      begin
        if (duty_wr.wr_low)
          duty_compare_low_ff <= duty_wr.data;
        if (duty_wr.wr_high)
          duty_compare_high_ff <= duty_wr.data;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_pin_inverse: assert property
    (modulated_output_pin == ~output_toggle_flop)
    else $error("pin is not the inverse of the flop");

  a_stop_clears: assert property
    (ce && !run |=> count_ff == CNT_RST)
    else $error("stopped counter not zero");

  a_timer_step: assert property
    (ce && mode == TCP_MODE_TIMER && step && !period_hit
     |=> count_ff == $past(count_ff) + CNT_ONE)
    else $error("timer did not advance by one");

  a_timer_wrap: assert property
    (ce && mode == TCP_MODE_TIMER && step && period_hit
     |=> cascade_match_irq && count_ff == CNT_RST)
    else $error("timer match did not clear and interrupt");

  a_event_step: assert property
    (ce && mode == TCP_MODE_EVENT && run && ext_fall && !period_hit
     |=> count_ff == $past(count_ff) + CNT_ONE)
    else $error("event edge not counted");

  a_event_match: assert property
    (ce && mode == TCP_MODE_EVENT && run && ext_fall && period_hit
     |=> cascade_match_irq && count_ff == CNT_RST)
    else $error("event match not handled");

  a_pwm_overflow: assert property
    (ce && is_pwm && step && overflow && duty_val != CNT_RST
     |=> cascade_match_irq && count_ff == CNT_RST
         && output_toggle_flop != $past(flop_ff))
    else $error("overflow did not toggle, clear and interrupt");

  a_pwm_duty_hit: assert property
    (ce && is_pwm && step && !overflow && duty_hit
     |=> output_toggle_flop != $past(flop_ff) && count_ff != CNT_RST)
    else $error("duty match did not toggle");

  a_duty_held: assert property
    (ce && buffered && !irq_evt |=> $stable(duty_compare))
    else $error("active duty changed outside the irq");

  a_duty_direct: assert property
    (ce && !buffered && duty_wr.wr_high
     |=> duty_compare[15:8] == $past(duty_wr.data))
    else $error("stopped duty write not applied at once");

  a_stop_holds: assert property
    (ce && ctrl_wr.wr && run && !next_run && !toggle
     |=> $stable(output_toggle_flop) [*2])
    else $error("pin level changed on stop");

  a_preset_bit: assert property
    (ce && ctrl_wr.wr && !run && !next_run
     |=> output_toggle_flop == $past(ctrl_wr.data[FFI_BIT])
         && !upper_control_register[RUN_BIT])
    else $error("flop preset from bit 7 failed");

  a_period_now: assert property
    (ce && period_wr.wr_low
     |=> period_compare[7:0] == $past(period_wr.data))
    else $error("period write not immediate");

endmodule
`default_nettype wire

/* sim/tcp_pulse_src.sv */
// Purpose: external pulse source for the event count input
// Assumes: driven from the bench clock, the requested number of pulses per send
// Notes:   idles high so no edge is seen between bursts
`default_nettype none
`timescale 1ns/1ns
module tcp_pulse_src
#(
  parameter int HOLD = 4
)
(
  input  wire logic clock,
  output var  logic pin
);
  initial pin = 1'b1;

  task automatic send(input int pulses);
    repeat (pulses)
    begin
      @(posedge clock);
      pin <= 1'b0;
      repeat (HOLD) @(posedge clock);
      pin <= 1'b1;
      repeat (HOLD) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

/* sim/test_cascaded_16bit_timer_event_pwm.sv */
// Purpose: self-checking bench of the cascaded 16-bit timer
// Assumes: inputs change on rising edges, outputs read on falling ones
// Notes:   one PWM period spans 65536 system clocks
`default_nettype none
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module test_cascaded_16bit_timer_event_pwm;
  import tcp_pkg::*;
  logic         clock;
  logic         rst_b    = 1'b0;
  tcp_mode_t    mode     = TCP_MODE_TIMER;
  tcp_src_t     src_sel  = TCP_SRC_TAP0;
  tcp_clk_cfg_t clk_cfg  = '0;
  tcp_ticks_t   ticks    = '0;
  tcp_ctrl_wr_t ctrl_wr  = '0;
  tcp_cmp_wr_t  cmp_bus  = '0;
  logic         cmp_duty = 1'b0;
  tcp_cmp_wr_t  period_wr;
  tcp_cmp_wr_t  duty_wr;
  logic         ext_pin;
  logic [7:0]   ctrl_q;
  logic [15:0]  period_q;
  logic [15:0]  duty_q;
  logic [15:0]  count_q;
  logic         flop_q;
  logic         pin_q;
  logic         irq_q;
  int           n_fail          = 0;
  int           samples_checked = 0;
  int           n_irq           = 0;
  int           n;
  int           base;
  logic [7:0]   tap_mask [5]    = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h40};

  assign period_wr = cmp_duty ? '0 : cmp_bus;
  assign duty_wr   = cmp_duty ? cmp_bus : '0;

  tcp_timer16 #(.CNT_WIDTH(16)) u_dut
  (
    .clock                  (clock),
    .rst_b                  (rst_b),
    .ce                     (1'b1),
    .mode                   (mode),
    .src_sel                (src_sel),
    .clk_cfg                (clk_cfg),
    .ticks                  (ticks),
    .ctrl_wr                (ctrl_wr),
    .period_wr              (period_wr),
    .duty_wr                (duty_wr),
    .external_count_input   (ext_pin),
    .upper_control_register (ctrl_q),
    .period_compare         (period_q),
    .duty_compare           (duty_q),
    .count_value            (count_q),
    .output_toggle_flop     (flop_q),
    .modulated_output_pin   (pin_q),
    .cascade_match_irq      (irq_q)
  );

  tcp_pulse_src #(.HOLD(4)) u_src
  (
    .clock (clock),
    .pin   (ext_pin)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
    if (irq_q === 1'b1)
      n_irq <= n_irq + 1;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr_ctrl(input logic [7:0] value);
    @(posedge clock);
    ctrl_wr <= '{wr: 1'b1, data: value};
    @(posedge clock);
    ctrl_wr.wr <= 1'b0;
  endtask

  task automatic wr_cmp(input logic to_duty, input logic [15:0] value);
    @(posedge clock);
    cmp_duty <= to_duty;
    cmp_bus  <= '{wr_low: 1'b1, wr_high: 1'b0, data: value[7:0]};
    @(posedge clock);
    cmp_bus  <= '{wr_low: 1'b0, wr_high: 1'b1, data: value[15:8]};
    @(posedge clock);
    cmp_bus  <= '0;
  endtask

  task automatic wait_irq(output int cycles);
    cycles = 0;
    do
    begin
      @(negedge clock);
      cycles++;
    end
    while (irq_q !== 1'b1 && cycles < 70000);
    `CHK(irq_q, 1'b1)
  endtask

  initial
  begin
    repeat (80000) @(posedge clock);
    n_fail++;
    finish_test;
  end

  initial
  begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    `CHK({ctrl_q, count_q, irq_q}, 25'h0)
    `CHK({flop_q, pin_q}, 2'b01)
    wr_cmp(1'b0, 16'h0103);
    @(negedge clock);
    `CHK(period_q, 16'h0103)
    for (int k = 0; k < 5; k++)
    begin
      wr_ctrl(8'h00);
      src_sel <= (k == 4) ? TCP_SRC_TAP0 : tcp_src_t'(k);
      clk_cfg <= '{low_speed: 1'b0, prescaler_tap_select: (k == 4)};
      ticks   <= tcp_ticks_t'(~tap_mask[k]);
      wr_ctrl(8'h08);
      repeat (6) @(negedge clock);
      `CHK(count_q, CNT_RST)
      @(posedge clock);
      ticks <= tcp_ticks_t'(tap_mask[k]);
      wait_irq(n);
      wait_irq(n);
      `CHK(n, 259)
    end
    wr_ctrl(8'h00);
    src_sel <= TCP_SRC_TAP1;
    clk_cfg <= '{low_speed: 1'b1, prescaler_tap_select: 1'b0};
    ticks   <= tcp_ticks_t'(8'hFF);
    wr_ctrl(8'h08);
    repeat (6) @(negedge clock);
    `CHK(count_q, CNT_RST)
    wr_ctrl(8'h00);
    src_sel <= TCP_SRC_TAP0;
    ticks   <= tcp_ticks_t'(8'h40);
    wr_ctrl(8'h08);
    repeat (4) @(negedge clock);
    `CHK(count_q, 16'h0003)
    wr_ctrl(8'h00);
    mode <= TCP_MODE_EVENT;
    wr_cmp(1'b0, 16'h0005);
    wr_ctrl(8'h08);
    base = n_irq;
    u_src.send(5);
    repeat (4) @(negedge clock);
    `CHK(n_irq - base, 1)
    `CHK(count_q, CNT_RST)
    u_src.send(2);
    repeat (4) @(negedge clock);
    `CHK(count_q, 16'h0002)
    wr_ctrl(8'h00);
    mode    <= TCP_MODE_PWM;
    src_sel <= TCP_SRC_HF;
    clk_cfg <= '0;
    ticks   <= tcp_ticks_t'(8'h01);
    wr_cmp(1'b1, 16'h0010);
    @(negedge clock);
    `CHK(duty_q, 16'h0010)
    wr_ctrl(8'hF7);
    @(negedge clock);
    `CHK({ctrl_q, flop_q, pin_q}, 10'h202)
    wr_ctrl(8'h00);
    @(negedge clock);
    `CHK({flop_q, pin_q}, 2'b01)
    wr_ctrl(8'h08);
    repeat (8) @(negedge clock);
    `CHK(flop_q, 1'b0)
    repeat (16) @(negedge clock);
    `CHK({flop_q, pin_q}, 2'b10)
    wr_cmp(1'b1, 16'h0020);
    @(negedge clock);
    `CHK(duty_q, 16'h0010)
    wait_irq(n);
    repeat (3) @(negedge clock);
    `CHK({duty_q, flop_q}, 17'h00040)
    repeat (20) @(negedge clock);
    `CHK(flop_q, 1'b0)
    repeat (16) @(negedge clock);
    `CHK(flop_q, 1'b1)
    wr_ctrl(8'h00);
    repeat (2) @(negedge clock);
    `CHK({count_q, flop_q}, 17'h00001)
    wr_ctrl(8'h00);
    @(negedge clock);
    `CHK(pin_q, 1'b1)
    @(posedge clock);
    clk_cfg <= '{low_speed: 1'b1, prescaler_tap_select: 1'b0};
    src_sel <= TCP_SRC_HF2;
    ticks   <= tcp_ticks_t'(8'h03);
    wr_ctrl(8'h08);
    repeat (4) @(negedge clock);
    `CHK(count_q, CNT_RST)
    wr_ctrl(8'h00);
    src_sel <= TCP_SRC_LF;
    ticks   <= tcp_ticks_t'(8'h04);
    wr_ctrl(8'h08);
    repeat (4) @(negedge clock);
    `CHK(count_q, 16'h0003)
    wr_ctrl(8'h00);
    src_sel <= TCP_SRC_EXT;
    wr_ctrl(8'h08);
    u_src.send(2);
    repeat (4) @(negedge clock);
    `CHK(count_q, 16'h0002)
    wr_ctrl(8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
